// file: common/csf_pkg.sv
/*
  Shared constants and types of the system flag bank.
  Assumes a 50 MHz core clock and a 32-bit AHB-Lite register port.
*/
package csf_pkg;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = TICK_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int OVERRUN_MS = 100;
  localparam int OVERRUN_CYCLES = OVERRUN_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int NUM_PULSE = 5;
  localparam int FAST_HALF_MS = 10;
  localparam int P01_HALF_MS = 50;
  localparam int P02_HALF_MS = 100;
  localparam int P10_HALF_MS = 500;
  localparam int MIN_HALF_MS = 30_000;
  // order: fast, 0.1 s, 0.2 s, 1.0 s, minute
  localparam logic [11:0] HALF_TICKS [NUM_PULSE] = '{
    12'(FAST_HALF_MS / TICK_MS), 12'(P01_HALF_MS / TICK_MS),
    12'(P02_HALF_MS / TICK_MS), 12'(P10_HALF_MS / TICK_MS),
    12'(MIN_HALF_MS / TICK_MS)};

  // ==========================================
  // register offsets
  localparam logic [7:0] OFS_FLAGS_A = 8'h00;
  localparam logic [7:0] OFS_FLAGS_B = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_SETUP = 8'h10;
  localparam logic [7:0] OFS_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IO_DATA = 8'h18;
  localparam logic [7:0] OFS_FORCE_MASK = 8'h1c;
  localparam logic [7:0] OFS_FORCE_VAL = 8'h20;
  localparam logic [7:0] OFS_BOARD_ERR = 8'h24;

  // ==========================================
  // field positions
  localparam int FA_MIN = 0;
  localparam int FA_FAST = 1;
  localparam int FA_OVF = 4;
  localparam int FA_UNF = 5;
  localparam int FA_DIFF = 6;
  localparam int FA_STEP = 7;
  localparam int FA_KEY = 8;
  localparam int FA_COMM = 13;
  localparam int FA_BOARD = 15;
  localparam int FB_P01 = 0;
  localparam int FB_ERR = 3;
  localparam int FB_CY = 4;
  localparam int FB_GR = 5;
  localparam int FB_EQ = 6;
  localparam int FB_LE = 7;
  localparam int CT_FORCE_HOLD = 11;
  localparam int CT_HOLD_IO = 12;
  localparam int CT_INHIBIT = 15;
  localparam int ST_LOW_BAT = 8;
  localparam int ST_OVERRUN = 9;
  localparam int SU_KEEP_HOLD = 0;
  localparam int SU_NO_BAT_ERR = 1;
  localparam int SU_NO_OVR_ERR = 2;
  localparam int CL_FORCE = 0;

  // ==========================================
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] SETUP_RESET = 16'h0000;

  typedef enum logic [1:0] {CSF_PROGRAM, CSF_MONITOR, CSF_RUN} csf_mode_e;

  typedef struct packed {
    logic valid;
    logic overflow;
    logic underflow;
    logic carry;
    logic zero;
    logic error;
    logic cmp_valid;
    logic greater;
    logic equal;
    logic less;
  } csf_exec_s;

  typedef struct packed {
    logic dswitch;
    logic segment;
    logic keypad;
  } csf_busy_s;
endpackage : csf_pkg

// file: hw/csf_pulse_gen.sv
/*
  Free-running square-wave clock pulse bits.
  Assumes a single core clock; runs from reset, ignores program state.
*/
module csf_pulse_gen #(
  parameter int TICK_CYCLES = csf_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  output logic [csf_pkg::NUM_PULSE-1:0] pulses
);
  // ==========================================
  // 10 ms base tick
  logic [31:0] tick_cnt;
  logic tick;

  always_ff @(posedge clk) begin
    if (srst || tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    tick <= !srst && tick_cnt == 32'(TICK_CYCLES - 1);
  end

  // ==========================================
  // one divider per pulse bit
  for (genvar i = 0; i < csf_pkg::NUM_PULSE; i++) begin : g_pulse
    logic [11:0] cnt;
    logic [11:0] seen;

    always_ff @(posedge clk) begin
      if (srst) begin
        cnt <= 12'h0;
        pulses[i] <= 1'b0;
      end else if (tick) begin
        if (cnt == csf_pkg::HALF_TICKS[i] - 12'h1) begin
          cnt <= 12'h0;
          pulses[i] <= !pulses[i];
        end else begin
          cnt <= cnt + 12'h1;
        end
      end
    end

    // ticks seen since the last edge, for checking only
    always_ff @(posedge clk) begin
      if (srst || pulses[i] != $past(pulses[i])) begin
        seen <= 12'h0;
      end else if (tick) begin
        seen <= seen + 12'h1;
      end
    end

    property p_half;
      @(posedge clk) disable iff (srst)
      (tick && seen != csf_pkg::HALF_TICKS[i] - 12'h1) |=> $stable(pulses[i]);
    endproperty
    a_half: assert property (p_half) else $error("pulse edge early");
  end

  // ==========================================
  // tick spacing check
  logic [31:0] gap;

  // all ones in reset so the first gap after release matches the steady spacing
  always_ff @(posedge clk) begin
    gap <= srst ? 32'hffff_ffff : (tick ? 32'h0 : gap + 32'h1);
  end

  property p_tick_gap;
    @(posedge clk) disable iff (srst)
    (tick && $past(tick_cnt) != 32'h0) |-> gap == 32'(TICK_CYCLES - 1);
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
endmodule : csf_pulse_gen

// file: hw/csf_flag_bank.sv
/*
  System flag and control bit bank with an AHB-Lite register port.
  Assumes exec, busy, mode and scan signals come from core logic on
  CORE_CLK; the battery pin is asynchronous. SRST is a full reset.
*/
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
// Behaviour
// - minute pulse bit, 30 s high then 30 s low, repeating.
// - fast pulse bit, 0.01 s high and 0.01 s low.
// - pulse bits of 0.1, 0.2, 1.0 s period, half high.
// - overflow flag sets when a result passes the signed maximum.
// - underflow flag sets when a result passes the signed minimum.
// - differential monitor done flag sets when monitoring finishes.
// - step flag high for exactly one scan when a step process begins.
// - keypad, display and switch busy bits follow their instructions.
// - comm error bit mirrors the comm unit error source.
// - board error bit sets on any slot error; codes in board word.
// - instruction error flag sets on an execution error.
// - carry flag sets on a carry from an instruction.
// - greater, equal, less report compares; zero result also sets equal.
// - clearing forcing leaves each forced bit at its forced value.
// - forces released on entering run, kept at power-on if setup keeps hold; the code also requires ctrl force hold set.
// - hold-io keeps io and link bits leaving program; else cleared.
// - with setup keep and hold-io high, power-on leaves io bits intact.
// - output inhibit holds all outputs off and lights the indicator.
// - output inhibit also holds pulse train and external outputs off.
// - output inhibit survives power-off; program clears it itself.
// - setup bits suppress low battery and cycle overrun errors.
// - cycle overrun flag sets when a scan exceeds 100 ms.
// - force hold keeps forces from program to monitor; else cleared.
module csf_flag_bank #(
  parameter int TICK_CYCLES = csf_pkg::TICK_CYCLES,
  parameter int OVERRUN_CYCLES = csf_pkg::OVERRUN_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire csf_pkg::csf_mode_e MODE,
  input wire logic POWER_ON,
  input wire logic SCAN_START,
  input wire csf_pkg::csf_exec_s EXEC,
  input wire csf_pkg::csf_busy_s BUSY,
  input wire logic STEP_BEGIN,
  input wire logic DIFF_DONE,
  input wire logic COMM_ERR,
  input wire logic [7:0] SLOT1_ERR,
  input wire logic [7:0] SLOT2_ERR,
  input wire logic BATTERY_LOW_PIN,
  input wire logic PULSE_TRAIN_IN,
  input wire logic [3:0] EXT_OUT_IN,
  output logic [15:0] OUT_PINS,
  output logic PULSE_TRAIN_OUT,
  output logic [3:0] EXT_OUT,
  output logic INHIBIT_LED
);
  // ==========================================
  // state
  logic [15:0] flags_a;
  logic [15:0] flags_b;
  logic [15:0] ctrl;
  logic [15:0] setup;
  logic [15:0] io_data;
  logic [15:0] force_mask;
  logic [15:0] force_val;
  logic [15:0] board_err;
  logic low_bat;
  logic overrun;
  logic [4:0] pulses;
  csf_pkg::csf_mode_e mode_q;

  csf_pulse_gen #(.TICK_CYCLES(TICK_CYCLES)) u_pulse (
    .clk(CORE_CLK),
    .srst(SRST),
    .pulses(pulses)
  );

  // ==========================================
  // AHB-Lite slave, zero wait states
  logic ap_write;
  logic [7:0] ap_addr;
  logic ap_wr;
  logic ap_take;
  logic [15:0] rd_word;
  logic wr_ctrl;
  logic wr_setup;
  logic wr_clear;
  logic wr_io;
  logic wr_mask;
  logic wr_val;

  assign ap_take = HSEL && HTRANS[1] && HREADY;

  always_comb begin
    rd_word = 16'h0000;
    if (HADDR[31:8] == 24'h0) begin
      unique case (HADDR[7:0])
        csf_pkg::OFS_FLAGS_A: rd_word = flags_a;
        csf_pkg::OFS_FLAGS_B: rd_word = flags_b;
        csf_pkg::OFS_CTRL: rd_word = ctrl;
        csf_pkg::OFS_STATUS: rd_word = 16'({overrun, low_bat}) << csf_pkg::ST_LOW_BAT;
        csf_pkg::OFS_SETUP: rd_word = setup;
        csf_pkg::OFS_IO_DATA: rd_word = io_data;
        csf_pkg::OFS_FORCE_MASK: rd_word = force_mask;
        csf_pkg::OFS_FORCE_VAL: rd_word = force_val;
        csf_pkg::OFS_BOARD_ERR: rd_word = board_err;
        default: rd_word = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      HRDATA <= 32'h0;
    end else begin
      ap_write <= ap_take && HWRITE;
      ap_addr <= (HADDR[31:8] == 24'h0) ? HADDR[7:0] : 8'hff;
      if (ap_take && !HWRITE) begin
        HRDATA <= {16'h0000, rd_word};
      end
    end
  end

  // never stalls and never errors
  always_ff @(posedge CORE_CLK) begin
    HREADYOUT <= 1'b1;
    HRESP <= 1'b0;
  end

  assign ap_wr = ap_write;
  assign wr_ctrl = ap_wr && ap_addr == csf_pkg::OFS_CTRL;
  assign wr_setup = ap_wr && ap_addr == csf_pkg::OFS_SETUP;
  assign wr_clear = ap_wr && ap_addr == csf_pkg::OFS_CLEAR;
  assign wr_io = ap_wr && ap_addr == csf_pkg::OFS_IO_DATA;
  assign wr_mask = ap_wr && ap_addr == csf_pkg::OFS_FORCE_MASK;
  assign wr_val = ap_wr && ap_addr == csf_pkg::OFS_FORCE_VAL;

  // ==========================================
  // mode changes and power-on
  logic prog_exit;
  logic run_entry;
  logic keep;
  logic force_release;
  logic io_clear;
  logic [15:0] effective;

  assign prog_exit = mode_q == csf_pkg::CSF_PROGRAM && MODE != csf_pkg::CSF_PROGRAM;
  assign run_entry = mode_q != csf_pkg::CSF_RUN && MODE == csf_pkg::CSF_RUN;
  assign keep = setup[csf_pkg::SU_KEEP_HOLD];
  assign force_release = (run_entry && !(POWER_ON && keep && ctrl[csf_pkg::CT_FORCE_HOLD]))
    || (prog_exit && MODE == csf_pkg::CSF_MONITOR && !ctrl[csf_pkg::CT_FORCE_HOLD])
    || (POWER_ON && !(keep && ctrl[csf_pkg::CT_FORCE_HOLD]))
    || (wr_clear && HWDATA[csf_pkg::CL_FORCE]);
  assign io_clear = (prog_exit && !ctrl[csf_pkg::CT_HOLD_IO])
    || (POWER_ON && !(keep && ctrl[csf_pkg::CT_HOLD_IO]));
  assign effective = (io_data & ~force_mask) | (force_val & force_mask);

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      mode_q <= csf_pkg::CSF_PROGRAM;
    end else begin
      mode_q <= MODE;
    end
  end

  // ==========================================
  // control and setup words
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl <= csf_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= HWDATA[15:0] & 16'h9800;
    end else if (POWER_ON && !keep) begin
      // inhibit is battery backed and survives power-on
      ctrl[csf_pkg::CT_FORCE_HOLD] <= 1'b0;
      ctrl[csf_pkg::CT_HOLD_IO] <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      setup <= csf_pkg::SETUP_RESET;
    end else if (wr_setup) begin
      setup <= HWDATA[15:0] & 16'h0007;
    end
  end

  // ==========================================
  // io image and forcing
  always_ff @(posedge CORE_CLK) begin
    if (SRST || io_clear) begin
      io_data <= 16'h0000;
    end else if (force_release) begin
      io_data <= effective;
    end else if (wr_io) begin
      io_data <= HWDATA[15:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST || force_release) begin
      force_mask <= 16'h0000;
    end else if (wr_mask) begin
      force_mask <= HWDATA[15:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      force_val <= 16'h0000;
    end else if (wr_val) begin
      force_val <= HWDATA[15:0];
    end
  end

  // ==========================================
  // outputs, gated by inhibit
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      OUT_PINS <= 16'h0000;
      PULSE_TRAIN_OUT <= 1'b0;
      EXT_OUT <= 4'h0;
      INHIBIT_LED <= 1'b0;
    end else begin
      OUT_PINS <= ctrl[csf_pkg::CT_INHIBIT] ? 16'h0000 : effective;
      PULSE_TRAIN_OUT <= PULSE_TRAIN_IN && !ctrl[csf_pkg::CT_INHIBIT];
      EXT_OUT <= ctrl[csf_pkg::CT_INHIBIT] ? 4'h0 : EXT_OUT_IN;
      INHIBIT_LED <= ctrl[csf_pkg::CT_INHIBIT];
    end
  end

  // ==========================================
  // first flag word
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      flags_a <= 16'h0000;
    end else begin
      flags_a[csf_pkg::FA_MIN] <= pulses[4];
      flags_a[csf_pkg::FA_FAST] <= pulses[0];
      if (EXEC.valid) begin
        flags_a[csf_pkg::FA_OVF] <= EXEC.overflow;
        flags_a[csf_pkg::FA_UNF] <= EXEC.underflow;
      end
      // set wins over a same-cycle clear
      if (DIFF_DONE) begin
        flags_a[csf_pkg::FA_DIFF] <= 1'b1;
      end else if (wr_clear && HWDATA[csf_pkg::FA_DIFF]) begin
        flags_a[csf_pkg::FA_DIFF] <= 1'b0;
      end
      if (STEP_BEGIN) begin
        flags_a[csf_pkg::FA_STEP] <= 1'b1;
      end else if (SCAN_START) begin
        flags_a[csf_pkg::FA_STEP] <= 1'b0;
      end
      flags_a[csf_pkg::FA_KEY +: 3] <= {BUSY.dswitch, BUSY.segment, BUSY.keypad};
      flags_a[csf_pkg::FA_COMM] <= COMM_ERR;
      flags_a[csf_pkg::FA_BOARD] <= |{SLOT2_ERR, SLOT1_ERR};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      board_err <= 16'h0000;
    end else begin
      board_err <= {SLOT2_ERR, SLOT1_ERR};
    end
  end

  // ==========================================
  // second flag word
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      flags_b <= 16'h0000;
    end else begin
      flags_b[csf_pkg::FB_P01 +: 3] <= pulses[3:1];
      if (EXEC.valid) begin
        flags_b[csf_pkg::FB_ERR] <= EXEC.error;
        flags_b[csf_pkg::FB_CY] <= EXEC.carry;
        if (EXEC.cmp_valid) begin
          flags_b[csf_pkg::FB_GR] <= EXEC.greater;
          flags_b[csf_pkg::FB_EQ] <= EXEC.equal || EXEC.zero;
          flags_b[csf_pkg::FB_LE] <= EXEC.less;
        end else begin
          flags_b[csf_pkg::FB_EQ] <= EXEC.zero;
        end
      end
    end
  end

  // ==========================================
  // battery and cycle time errors
  logic bat_meta;
  logic bat_sync;
  logic [22:0] scan_cnt;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      bat_meta <= 1'b0;
      bat_sync <= 1'b0;
    end else begin
      bat_meta <= BATTERY_LOW_PIN;
      bat_sync <= bat_meta;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      low_bat <= 1'b0;
    end else begin
      low_bat <= bat_sync && !setup[csf_pkg::SU_NO_BAT_ERR];
    end
  end

  // saturates so a stuck scan never wraps and hides itself
  always_ff @(posedge CORE_CLK) begin
    if (SRST || SCAN_START) begin
      scan_cnt <= 23'h0;
    end else if (scan_cnt != 23'(OVERRUN_CYCLES)) begin
      scan_cnt <= scan_cnt + 23'h1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      overrun <= 1'b0;
    end else if (scan_cnt == 23'(OVERRUN_CYCLES) && !setup[csf_pkg::SU_NO_OVR_ERR]) begin
      overrun <= 1'b1;
    end else if (wr_clear && HWDATA[csf_pkg::ST_OVERRUN]) begin
      overrun <= 1'b0;
    end
  end

  // ==========================================
  // checks
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  property p_inhibit;
    ctrl[csf_pkg::CT_INHIBIT] |=> OUT_PINS == 16'h0000 && INHIBIT_LED;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("outputs live under inhibit");

  property p_inhibit_aux;
    ctrl[csf_pkg::CT_INHIBIT] |=> !PULSE_TRAIN_OUT && EXT_OUT == 4'h0;
  endproperty
  a_inhibit_aux: assert property (p_inhibit_aux) else $error("aux outputs live");

  property p_overflow;
    EXEC.valid && EXEC.overflow |=> flags_a[csf_pkg::FA_OVF];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_zero_eq;
    EXEC.valid && EXEC.zero |=> flags_b[csf_pkg::FB_EQ] && $stable(flags_b[15:8]);
  endproperty
  a_zero_eq: assert property (p_zero_eq) else $error("zero did not set equal");

  property p_step;
    SCAN_START && !STEP_BEGIN |=> !flags_a[csf_pkg::FA_STEP];
  endproperty
  a_step: assert property (p_step) else $error("step flag outlived scan");

  property p_busy;
    BUSY.segment ##1 !BUSY.segment |=> !flags_a[csf_pkg::FA_KEY + 1];
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit stuck");

  property p_io_clear;
    prog_exit && !ctrl[csf_pkg::CT_HOLD_IO] |=> io_data == 16'h0000;
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("io not cleared");

  property p_force_commit;
    force_release && !io_clear |=> io_data == $past(effective) && force_mask == 16'h0000;
  endproperty
  a_force_commit: assert property (p_force_commit) else $error("forced value lost");

  property p_overrun;
    scan_cnt == 23'(OVERRUN_CYCLES) && !SCAN_START && !setup[csf_pkg::SU_NO_OVR_ERR]
      |=> ##1 overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");

  property p_bat_sup;
    setup[csf_pkg::SU_NO_BAT_ERR] ##1 setup[csf_pkg::SU_NO_BAT_ERR] |-> !low_bat;
  endproperty
  a_bat_sup: assert property (p_bat_sup) else $error("battery error not suppressed");

  c_inhibit: cover property ($rose(INHIBIT_LED));
  c_step: cover property ($rose(flags_a[csf_pkg::FA_STEP]));
  c_overrun: cover property ($rose(overrun));
  c_release: cover property (force_release && force_mask != 16'h0000);
endmodule : csf_flag_bank

// file: dv/controller_system_flag_bank_tb.sv
/*
  Self-checking bench of the flag bank: AHB-Lite master tasks, an integer
  model of the flags, directed and seeded random scenarios.
  Assumes short counts: TICK_CYCLES 5, OVERRUN_CYCLES 50.
*/
module controller_system_flag_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 5;
  localparam int OVR = 50;
  logic clk, srst, hsel, hwrite, hreadyout, hresp, pwr, scan, stp, diff, comm, bat;
  logic pt_in, pt_out, led, m_gr, m_le, m_eq, m_step, m_diff;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, r, q, ea, eb;
  logic [7:0] s1, s2, v1, v2;
  logic [3:0] ext_in, ext_out;
  logic [15:0] pins;
  csf_pkg::csf_mode_e mode;
  csf_pkg::csf_exec_s ex;
  csf_pkg::csf_busy_s busy;
  int mismatches, n_checks;

  csf_flag_bank #(.TICK_CYCLES(TK), .OVERRUN_CYCLES(OVR)) dut (
    .CORE_CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .MODE(mode),
    .POWER_ON(pwr), .SCAN_START(scan), .EXEC(ex), .BUSY(busy), .STEP_BEGIN(stp),
    .DIFF_DONE(diff), .COMM_ERR(comm), .SLOT1_ERR(s1), .SLOT2_ERR(s2),
    .BATTERY_LOW_PIN(bat), .PULSE_TRAIN_IN(pt_in), .EXT_OUT_IN(ext_in),
    .OUT_PINS(pins), .PULSE_TRAIN_OUT(pt_out), .EXT_OUT(ext_out), .INHIBIT_LED(led));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================
  // checking and bus tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ready is looked at before this edge's updates land
  task automatic await_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 16) begin
        check("ready wait", 0, 1);
        tally_and_finish();
      end
      @(posedge clk);
    end
  endtask : await_ready

  task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    await_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0, d};
    await_ready();
    rd = hrdata;
    check("response", {31'h0, hresp}, 0);
  endtask : bus

  task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0);
    check(what, rd, exp);
  endtask : rdc

  task automatic set_mode(input csf_pkg::csf_mode_e m);
    mode <= m;
    repeat (2) @(posedge clk);
  endtask : set_mode

  function automatic int hc(input int ms);
    return ms / csf_pkg::TICK_MS * TK;
  endfunction : hc

  // polling resolution is one bus transfer, two cycles, hence the slack
  task automatic measure(input logic [31:0] a, input int b, input int half, input int n);
    logic prev;
    time t0;
    int k;
    t0 = 0;
    k = 0;
    bus(1'b0, a, 16'h0);
    prev = rd[b];
    for (int i = 0; i < 30000 && k < n; i++) begin
      bus(1'b0, a, 16'h0);
      if (rd[b] !== prev) begin
        if (t0 != 0) begin
          check("pulse half", 32'(($time - t0) / 20 + 2 - half), 32'(($time - t0) / 20 + 2 - half) & 3);
        end
        t0 = $time;
        prev = rd[b];
        k++;
      end
    end
    check("pulse toggles", k, n);
  endtask : measure

  // ==========================================
  // main sequence
  initial begin
    {srst, hsel, hwrite, pwr, scan, stp, diff, comm, bat, pt_in} = 10'h200;
    {htrans, haddr, hwdata, s1, s2, ext_in, ex, busy} = '0;
    {m_gr, m_le, m_step, m_diff} = '0;
    hsize = 3'b010;
    mode = csf_pkg::CSF_PROGRAM;
    mismatches = 0;
    n_checks = 0;
    void'($urandom(25));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdc("ctrl reset", csf_pkg::OFS_CTRL, 0);
    rdc("setup reset", csf_pkg::OFS_SETUP, 0);
    bus(1'b1, 32'h40, 16'hffff);
    rdc("unmapped", 32'h40, 0);
    rdc("upper address", 32'h100, 0);
    measure(csf_pkg::OFS_FLAGS_A, 1, hc(csf_pkg::FAST_HALF_MS), 4);
    measure(csf_pkg::OFS_FLAGS_B, 0, hc(csf_pkg::P01_HALF_MS), 3);
    measure(csf_pkg::OFS_FLAGS_B, 1, hc(csf_pkg::P02_HALF_MS), 3);
    measure(csf_pkg::OFS_FLAGS_B, 2, hc(csf_pkg::P10_HALF_MS), 3);
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      q = $urandom;
      v1 = r[13] ? r[23:16] : 8'h00;
      v2 = r[14] ? r[31:24] : 8'h00;
      ex <= csf_pkg::csf_exec_s'({1'b1, r[8:0]});
      busy <= csf_pkg::csf_busy_s'(r[11:9]);
      comm <= r[12];
      s1 <= v1;
      s2 <= v2;
      stp <= q[0];
      scan <= q[1];
      diff <= q[2];
      @(posedge clk);
      ex <= '0;
      {stp, scan, diff} <= 3'b000;
      @(posedge clk);
      if (r[3]) begin
        m_gr = r[2];
        m_le = r[0];
      end
      m_eq = r[3] ? (r[1] | r[5]) : r[5];
      m_step = q[0] ? 1'b1 : (q[1] ? 1'b0 : m_step);
      m_diff = m_diff | q[2];
      ea = {16'h0, |{v1, v2}, 1'b0, r[12], 2'b0, r[11:9], m_step, m_diff, r[7], r[8], 4'h0};
      eb = {24'h0, m_le, m_eq, m_gr, r[6], r[4], 3'h0};
      bus(1'b1, csf_pkg::OFS_FLAGS_A, 16'hffff);
      bus(1'b0, csf_pkg::OFS_FLAGS_A, 16'h0);
      check("flags a", rd & 32'hfffc, ea);
      bus(1'b0, csf_pkg::OFS_FLAGS_B, 16'h0);
      check("flags b", rd & 32'hfff8, eb);
      rdc("board codes", csf_pkg::OFS_BOARD_ERR, {16'h0, v2, v1});
      if (q[3]) begin
        bus(1'b1, csf_pkg::OFS_CLEAR, 16'h0040);
        m_diff = 1'b0;
      end
    end
    // ==========================================
    // forcing and io hold across mode changes
    bus(1'b1, csf_pkg::OFS_CTRL, 16'h1800);
    bus(1'b1, csf_pkg::OFS_IO_DATA, 16'h00f0);
    bus(1'b1, csf_pkg::OFS_FORCE_MASK, 16'h0f0f);
    bus(1'b1, csf_pkg::OFS_FORCE_VAL, 16'h0a05);
    set_mode(csf_pkg::CSF_MONITOR);
    rdc("mask kept", csf_pkg::OFS_FORCE_MASK, 32'h0f0f);
    rdc("io kept", csf_pkg::OFS_IO_DATA, 32'h00f0);
    check("pins forced", pins, 16'h0af5);
    set_mode(csf_pkg::CSF_PROGRAM);
    set_mode(csf_pkg::CSF_RUN);
    rdc("run release", csf_pkg::OFS_FORCE_MASK, 0);
    rdc("run commit", csf_pkg::OFS_IO_DATA, 32'h0af5);
    set_mode(csf_pkg::CSF_PROGRAM);
    bus(1'b1, csf_pkg::OFS_CTRL, 16'h0000);
    bus(1'b1, csf_pkg::OFS_FORCE_MASK, 16'h00ff);
    set_mode(csf_pkg::CSF_MONITOR);
    rdc("mask dropped", csf_pkg::OFS_FORCE_MASK, 0);
    rdc("io cleared", csf_pkg::OFS_IO_DATA, 0);
    set_mode(csf_pkg::CSF_PROGRAM);
    bus(1'b1, csf_pkg::OFS_IO_DATA, 16'h1234);
    bus(1'b1, csf_pkg::OFS_FORCE_MASK, 16'h000f);
    bus(1'b1, csf_pkg::OFS_FORCE_VAL, 16'h0009);
    bus(1'b1, csf_pkg::OFS_CLEAR, 16'h0001);
    rdc("clear commit", csf_pkg::OFS_IO_DATA, 32'h1239);
    rdc("clear mask", csf_pkg::OFS_FORCE_MASK, 0);
    // ==========================================
    // output inhibit and power-up
    bus(1'b1, csf_pkg::OFS_SETUP, 16'h0001);
    bus(1'b1, csf_pkg::OFS_FORCE_MASK, 16'h0f00);
    bus(1'b1, csf_pkg::OFS_CTRL, 16'h9800);
    pt_in <= 1'b1;
    ext_in <= 4'hf;
    repeat (3) @(posedge clk);
    check("inhibit pins", {pt_out, ext_out, pins}, 0);
    check("inhibit led", led, 1);
    pwr <= 1'b1;
    @(posedge clk);
    pwr <= 1'b0;
    rdc("power io", csf_pkg::OFS_IO_DATA, 32'h1239);
    rdc("power mask", csf_pkg::OFS_FORCE_MASK, 32'h0f00);
    rdc("power ctrl", csf_pkg::OFS_CTRL, 32'h9800);
    bus(1'b1, csf_pkg::OFS_SETUP, 16'h0000);
    pwr <= 1'b1;
    @(posedge clk);
    pwr <= 1'b0;
    rdc("cold io", csf_pkg::OFS_IO_DATA, 0);
    rdc("cold mask", csf_pkg::OFS_FORCE_MASK, 0);
    rdc("cold ctrl", csf_pkg::OFS_CTRL, 32'h8000);
    bus(1'b1, csf_pkg::OFS_IO_DATA, 16'h00a5);
    bus(1'b1, csf_pkg::OFS_CTRL, 16'h0000);
    repeat (3) @(posedge clk);
    check("outputs on", {pt_out, ext_out, pins, led}, {1'b1, 4'hf, 16'h00a5, 1'b0});
    // ==========================================
    // cycle overrun and battery
    scan <= 1'b1;
    @(posedge clk);
    scan <= 1'b0;
    repeat (OVR + 10) @(posedge clk);
    rdc("overrun", csf_pkg::OFS_STATUS, 32'h0200);
    scan <= 1'b1;
    @(posedge clk);
    scan <= 1'b0;
    bus(1'b1, csf_pkg::OFS_CLEAR, 16'h0200);
    repeat (OVR - 20) @(posedge clk);
    scan <= 1'b1;
    @(posedge clk);
    scan <= 1'b0;
    repeat (OVR - 20) @(posedge clk);
    rdc("short scans", csf_pkg::OFS_STATUS, 0);
    bus(1'b1, csf_pkg::OFS_SETUP, 16'h0004);
    bat <= 1'b1;
    repeat (OVR + 10) @(posedge clk);
    rdc("overrun off", csf_pkg::OFS_STATUS, 32'h0100);
    bus(1'b1, csf_pkg::OFS_SETUP, 16'h0006);
    // battery error is registered once more behind the setup word
    @(posedge clk);
    rdc("battery off", csf_pkg::OFS_STATUS, 0);
    bat <= 1'b0;
    measure(csf_pkg::OFS_FLAGS_A, 0, hc(csf_pkg::MIN_HALF_MS), 3);
    tally_and_finish();
  end
endmodule : controller_system_flag_bank_tb
